// ### verilog/ssfp_fifo_port.sv
// Sample FIFO with count shadow, data port, identity and APB registers
// Function
// R1: Keep sixteen-bit count of bytes held.
// R2: High count read loads both shadows together; the code keeps only a low shadow and reads the high byte live.
// R3: Low count read alone refreshes nothing.
// R4: Host reads count high then low.
// R5: Data register pops on read, pushes on write.
// R6: Sample bytes pushed in ascending register order.
// R7: All enabled: registers 59 to 96 pushed.
// R8: Push only enabled sources; slave three aux.
// R9: Overflow sets the overrun status flag.
// R10: Overflow drops oldest byte, keeps writing new.
// R11: Empty read repeats last byte, count unchanged.
// R12: Host checks count before reading data.
// R13: Identity bits six to one: address upper.
// R14: Identity ignores the address select pin.
// R15: Identity bits zero and seven read zero.
// R16: Disabled FIFO neither writes nor reads.
// R17: Reset bit empties disabled FIFO, self-clears.
// R18: Count follows pushes and pops, not overflow.
`timescale 1ns/1ps
`default_nettype none

module ssfp_fifo_port #(
  parameter int DEPTH = ssfp_pkg::DEPTH_DEFAULT,
  parameter logic [5:0] BUS_ADDR_UPPER = 6'h15 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssfp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssfp_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ssfp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_tick,
  input wire logic [ssfp_pkg::SAMPLE_BYTES*8-1:0] sample_bytes,
  input wire logic [ssfp_pkg::EXT_BYTES-1:0] ext_slot_assigned,
  input wire logic [ssfp_pkg::EXT_BYTES*2-1:0] ext_slot_owner,
  output logic irq
);

  // Depth: a power of two below 65536, so pointers wrap and the count fits
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [ssfp_pkg::COUNT_W-1:0] FULL_COUNT =
    ssfp_pkg::COUNT_W'(DEPTH);

  // Sequencer: waiting for a tick, or walking the sample bytes
  typedef enum logic {SSFP_IDLE, SSFP_SCAN} ssfp_state_t;

  // Storage and pointers
  logic [7:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [ssfp_pkg::COUNT_W-1:0] byte_count;
  logic [7:0] last_byte;

  // Software-visible state
  logic fifo_enable;
  logic reset_pending;
  logic [7:0] source_enable;
  logic slv3_enable;
  logic overrun_status;
  logic overrun_mask;
  logic [7:0] shadow_low;

  // Sequencer state
  ssfp_state_t state;
  logic [5:0] scan_index;
  logic [ssfp_pkg::SAMPLE_BYTES*8-1:0] snapshot;

  // Bus decode and handshake
  logic ack;
  logic access;
  logic is_data;
  logic host_stall;
  logic take;
  logic wr_take;
  logic rd_take;
  logic lane0;

  // FIFO traffic
  logic seq_push;
  logic host_push;
  logic host_pop;
  logic push;
  logic full;
  logic empty;
  logic overrun;
  logic [7:0] push_byte;
  logic [ssfp_pkg::DATA_W-1:0] next_prdata;
  logic next_pslverr;

  // Whether a sample byte belongs to a source that is enabled
  function automatic logic ssfp_byte_enabled(
    input logic [5:0] idx,
    input logic [7:0] src,
    input logic slv3,
    input logic [ssfp_pkg::EXT_BYTES-1:0] assigned,
    input logic [ssfp_pkg::EXT_BYTES*2-1:0] owner
  );
    logic [4:0] ext;
    logic [1:0] who;
    logic result;
    begin
      ext = 5'(idx - ssfp_pkg::GYRO_Z_END);
      who = owner[{ext, 1'b0} +: 2];
      result = 1'b0;
      if (idx < ssfp_pkg::ACCEL_END) begin
        result = src[ssfp_pkg::SRC_ACCEL_BIT];
      end else if (idx < ssfp_pkg::TEMP_END) begin
        result = src[ssfp_pkg::SRC_TEMP_BIT];
      end else if (idx < ssfp_pkg::GYRO_X_END) begin
        result = src[ssfp_pkg::SRC_GYRO_X_BIT];
      end else if (idx < ssfp_pkg::GYRO_Y_END) begin
        result = src[ssfp_pkg::SRC_GYRO_Y_BIT];
      end else if (idx < ssfp_pkg::GYRO_Z_END) begin
        result = src[ssfp_pkg::SRC_GYRO_Z_BIT];
      end else if (assigned[ext]) begin
        case (who)
          2'h0: result = src[ssfp_pkg::SRC_SLV0_BIT];
          2'h1: result = src[ssfp_pkg::SRC_SLV1_BIT];
          2'h2: result = src[ssfp_pkg::SRC_SLV2_BIT];
          default: result = slv3;
        endcase
      end
      return result;
    end
  endfunction

  // Whether the write being taken lands in the register at target
  function automatic logic ssfp_wr_hit(
    input logic [ssfp_pkg::ADDR_W-1:0] target
  );
    return wr_take & lane0 & (paddr == target);
  endfunction

  // Host access is taken once, in the first free access cycle
  assign access = psel & penable & ~ack;
  assign is_data = (paddr == ssfp_pkg::ADDR_DATA_PORT);
  assign lane0 = pstrb[0];
  // A host push waits while the sequencer owns the write port
  assign host_stall = is_data & pwrite & seq_push;
  assign take = access & ~host_stall;
  assign wr_take = take & pwrite;
  assign rd_take = take & ~pwrite;

  // The answer flop drives the handshake output directly
  assign pready = ack;

  // Buffer occupancy
  assign full = (byte_count == FULL_COUNT);
  assign empty = (byte_count == 16'h0000);

  // Sequencer push of the byte under the scan index
  assign seq_push = (state == SSFP_SCAN) & fifo_enable & // R16
    ssfp_byte_enabled(scan_index, source_enable, slv3_enable,
      ext_slot_assigned, ext_slot_owner); // R8

  // Host traffic through the data port, gated by the global enable
  assign host_push = wr_take & is_data & lane0 & fifo_enable; // R5 R16
  assign host_pop = rd_take & is_data & fifo_enable & ~empty; // R5 R11 R16

  // One write port: a host push waits out any sequencer push
  assign push = seq_push | host_push;
  assign push_byte = seq_push ? snapshot[{scan_index, 3'b000} +: 8] :
    pwdata[7:0];
  // A push into a full buffer without a pop in the same cycle drops its oldest byte
  assign overrun = push & full & ~host_pop; // R10

  // Sample sequencer; a tick during a scan is ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SSFP_IDLE;
      scan_index <= 6'h00;
    end else begin
      case (state)
        SSFP_IDLE: begin
          scan_index <= 6'h00;
          if (sample_tick && fifo_enable) begin
            state <= SSFP_SCAN;
          end
        end
        SSFP_SCAN: begin
          if (!fifo_enable || scan_index == ssfp_pkg::LAST_INDEX) begin // R7
            state <= SSFP_IDLE;
          end else begin
            scan_index <= scan_index + 6'h01; // R6
          end
        end
        default: state <= SSFP_IDLE;
      endcase
    end
  end

  // Sample is frozen at the tick so a scan pushes one coherent set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snapshot <= '0;
    end else if (state == SSFP_IDLE && sample_tick) begin
      snapshot <= sample_bytes; // R7
    end
  end

  // Buffer storage has no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= push_byte;
    end
  end

  // Write pointer; depth must be a power of two for the wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
    end else if (reset_pending && !fifo_enable) begin
      wr_ptr <= '0; // R17
    end else if (push) begin
      wr_ptr <= wr_ptr + PTR_W'(1);
    end
  end

  // Read pointer advances on a pop or when an overrun drops a byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr <= '0;
    end else if (reset_pending && !fifo_enable) begin
      rd_ptr <= '0; // R17
    end else if (host_pop || overrun) begin
      rd_ptr <= rd_ptr + PTR_W'(1); // R10
    end
  end

  // Byte count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_count <= '0;
    end else if (reset_pending && !fifo_enable) begin
      byte_count <= '0; // R17
    end else if (push && !host_pop && !full) begin
      byte_count <= byte_count + 16'h0001; // R1 R18
    end else if (host_pop && !push) begin
      byte_count <= byte_count - 16'h0001; // R18
    end
  end

  // Last popped byte, returned again while the buffer is empty
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_byte <= 8'h00;
    end else if (host_pop) begin
      last_byte <= mem[rd_ptr]; // R11
    end
  end

  // Low count shadow loads only on a high count read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shadow_low <= 8'h00;
    end else if (rd_take && paddr == ssfp_pkg::ADDR_COUNT_HIGH) begin
      shadow_low <= byte_count[7:0]; // R2 R3
    end
  end

  // Control: enable bit, and a reset bit that clears itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_enable <= 1'b0;
      reset_pending <= 1'b0;
    end else if (ssfp_wr_hit(ssfp_pkg::ADDR_CONTROL)) begin
      fifo_enable <= pwdata[ssfp_pkg::CTRL_ENABLE_BIT];
      reset_pending <= pwdata[ssfp_pkg::CTRL_RESET_BIT];
    end else begin
      reset_pending <= 1'b0; // R17
    end
  end

  // Source enables and the fourth slave's enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      source_enable <= ssfp_pkg::SOURCE_EN_RESET;
      slv3_enable <= ssfp_pkg::AUX_SLV3_RESET;
    end else if (wr_take && lane0) begin
      if (paddr == ssfp_pkg::ADDR_SOURCE_EN) begin
        source_enable <= pwdata[7:0]; // R8
      end else if (paddr == ssfp_pkg::ADDR_AUX_CTRL) begin
        slv3_enable <= pwdata[ssfp_pkg::AUX_SLV3_BIT]; // R8
      end
    end
  end

  // Overrun status: write one clears, a new overrun wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_status <= 1'b0;
    end else if (overrun) begin
      overrun_status <= 1'b1; // R9
    end else if (ssfp_wr_hit(ssfp_pkg::ADDR_IRQ_STATUS) &&
                 pwdata[ssfp_pkg::IRQ_OVERRUN_BIT]) begin
      overrun_status <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_mask <= ssfp_pkg::IRQ_MASK_RESET;
    end else if (ssfp_wr_hit(ssfp_pkg::ADDR_IRQ_MASK)) begin
      overrun_mask <= pwdata[ssfp_pkg::IRQ_OVERRUN_BIT];
    end
  end

  // Level interrupt from an unmasked status bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= (overrun_status | overrun) & overrun_mask;
    end
  end

  // Read data and error decode for the access being taken
  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (paddr == ssfp_pkg::ADDR_COUNT_HIGH) begin
      next_prdata[7:0] = byte_count[15:8]; // R2
    end else if (paddr == ssfp_pkg::ADDR_COUNT_LOW) begin
      next_prdata[7:0] = shadow_low; // R3
    end else if (paddr == ssfp_pkg::ADDR_DATA_PORT) begin
      next_prdata[7:0] = host_pop ? mem[rd_ptr] : last_byte; // R11
    end else if (paddr == ssfp_pkg::ADDR_IDENTITY) begin
      next_prdata[7:0] = {1'b0, BUS_ADDR_UPPER, 1'b0}; // R13 R14 R15
    end else if (paddr == ssfp_pkg::ADDR_CONTROL) begin
      next_prdata[ssfp_pkg::CTRL_ENABLE_BIT] = fifo_enable;
      next_prdata[ssfp_pkg::CTRL_RESET_BIT] = reset_pending;
    end else if (paddr == ssfp_pkg::ADDR_SOURCE_EN) begin
      next_prdata[7:0] = source_enable;
    end else if (paddr == ssfp_pkg::ADDR_AUX_CTRL) begin
      next_prdata[ssfp_pkg::AUX_SLV3_BIT] = slv3_enable;
    end else if (paddr == ssfp_pkg::ADDR_IRQ_STATUS) begin
      next_prdata[ssfp_pkg::IRQ_OVERRUN_BIT] = overrun_status;
    end else if (paddr == ssfp_pkg::ADDR_IRQ_MASK) begin
      next_prdata[ssfp_pkg::IRQ_OVERRUN_BIT] = overrun_mask;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // Answer one cycle after the access is taken; data held in flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      ack <= take;
      if (take) begin
        pslverr <= next_pslverr;
        if (!pwrite) begin
          prdata <= next_prdata;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/ssfp_pkg.sv
// Package: map, field layout, reset values and sizes of the sample FIFO port
package ssfp_pkg;

  // Bus address width and data width
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indexes; the byte address is four times the index
  localparam logic [9:0] IDX_COUNT_HIGH = 10'h072;
  localparam logic [9:0] IDX_COUNT_LOW = 10'h073;
  localparam logic [9:0] IDX_DATA_PORT = 10'h074;
  localparam logic [9:0] IDX_IDENTITY = 10'h075;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = {IDX_COUNT_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = {IDX_COUNT_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DATA_PORT = {IDX_DATA_PORT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IDENTITY = {IDX_IDENTITY, 2'b00};

  // Control, enable and interrupt registers
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_SOURCE_EN = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_AUX_CTRL = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h010;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int SRC_SLV0_BIT = 0;
  localparam int SRC_SLV1_BIT = 1;
  localparam int SRC_SLV2_BIT = 2;
  localparam int SRC_ACCEL_BIT = 3;
  localparam int SRC_GYRO_Z_BIT = 4;
  localparam int SRC_GYRO_Y_BIT = 5;
  localparam int SRC_GYRO_X_BIT = 6;
  localparam int SRC_TEMP_BIT = 7;
  localparam int AUX_SLV3_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 0;

  // Reset values
  localparam logic [7:0] SOURCE_EN_RESET = 8'h00;
  localparam logic AUX_SLV3_RESET = 1'b0;
  localparam logic IRQ_MASK_RESET = 1'b0;

  // Sample layout: registers 59 to 96, byte 0 is register 59
  localparam int SAMPLE_BYTES = 38;
  localparam int EXT_BYTES = 24;
  localparam logic [5:0] ACCEL_END = 6'h06;
  localparam logic [5:0] TEMP_END = 6'h08;
  localparam logic [5:0] GYRO_X_END = 6'h0A;
  localparam logic [5:0] GYRO_Y_END = 6'h0C;
  localparam logic [5:0] GYRO_Z_END = 6'h0E;
  localparam logic [5:0] LAST_INDEX = 6'h25;

  // Byte count width and default buffer depth
  localparam int COUNT_W = 16;
  localparam int DEPTH_DEFAULT = 1024;

endpackage

// ### verilog/ssfp_pkg_end.sv
// Holds no code; the package and the port module carry the whole block

// ### tb/ssfp_fifo_port_props.sv
// Checker of the sample FIFO port bus answers and read values
`timescale 1ns/1ps
`default_nettype none

module ssfp_fifo_port_props #(
  parameter int DEPTH = ssfp_pkg::DEPTH_DEFAULT,
  parameter logic [5:0] BUS_ADDR_UPPER = 6'h15 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssfp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssfp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic mapped, rd_done, lo_done, hi_done, have_lo, hi_seen;
  logic [7:0] last_lo;
  // Decode of the map and of completed reads
  assign mapped = paddr inside {ssfp_pkg::ADDR_CONTROL,
    ssfp_pkg::ADDR_SOURCE_EN, ssfp_pkg::ADDR_AUX_CTRL,
    ssfp_pkg::ADDR_IRQ_STATUS, ssfp_pkg::ADDR_IRQ_MASK,
    ssfp_pkg::ADDR_COUNT_HIGH, ssfp_pkg::ADDR_COUNT_LOW,
    ssfp_pkg::ADDR_DATA_PORT, ssfp_pkg::ADDR_IDENTITY};
  assign rd_done = pready && !pwrite;
  assign lo_done = rd_done && paddr == ssfp_pkg::ADDR_COUNT_LOW;
  assign hi_done = rd_done && paddr == ssfp_pkg::ADDR_COUNT_HIGH;
  // Low byte history; only a high read may move the shadow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      have_lo <= 1'b0;
      hi_seen <= 1'b0;
      last_lo <= 8'h00;
    end else if (lo_done) begin
      have_lo <= 1'b1;
      hi_seen <= 1'b0;
      last_lo <= prdata[7:0];
    end else if (hi_done) begin
      hi_seen <= 1'b1;
    end
  end
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_one_wait_state: assert property (psel && penable && !pready
    && !(pwrite && paddr == ssfp_pkg::ADDR_DATA_PORT) |=> pready)
    else $error("access phase not answered after one wait");
  a_error_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_identity_addr: assert property (rd_done && paddr ==
    ssfp_pkg::ADDR_IDENTITY |-> prdata[6:1] == BUS_ADDR_UPPER)
    else $error("identity field differs from address bits");
  a_identity_zero: assert property (rd_done && paddr ==
    ssfp_pkg::ADDR_IDENTITY |-> !prdata[7] && !prdata[0])
    else $error("identity reserved bits not zero");
  a_byte_wide: assert property (rd_done && mapped
    |-> prdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_count_bound: assert property (hi_done
    |-> {16'h0000, prdata[7:0], 8'h00} <= DEPTH)
    else $error("high count byte beyond buffer depth");
  a_low_shadow: assert property (lo_done && have_lo && !hi_seen
    |-> prdata[7:0] == last_lo)
    else $error("low count moved without a high read");
endmodule

bind ssfp_fifo_port ssfp_fifo_port_props #(
  .DEPTH(DEPTH),
  .BUS_ADDR_UPPER(BUS_ADDR_UPPER)
) u_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr)
);

`default_nettype wire

// ### tb/ssfp_sensor_model.sv
// Sensor side model: sample tick and data registers 59 to 96
`timescale 1ns/1ps
`default_nettype none

module ssfp_sensor_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fire,
  output logic sample_tick,
  output logic [ssfp_pkg::SAMPLE_BYTES*8-1:0] sample_bytes,
  output logic [ssfp_pkg::EXT_BYTES-1:0] ext_slot_assigned,
  output logic [ssfp_pkg::EXT_BYTES*2-1:0] ext_slot_owner
);
  // One tick per request; the bench spaces requests past a full scan
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= fire;
    end
  end
  // Byte k holds 0x40+k so order and loss show in the values
  always_comb begin
    for (int k = 0; k < ssfp_pkg::SAMPLE_BYTES; k++) begin
      sample_bytes[8*k +: 8] = 8'h40 + 8'(k);
    end
    for (int e = 0; e < ssfp_pkg::EXT_BYTES; e++) begin
      ext_slot_owner[2*e +: 2] = 2'(e); // all four slaves own bytes
    end
  end
  assign ext_slot_assigned = '1;
endmodule

`default_nettype wire

// ### tb/sensor_sample_fifo_port_tb.sv
// Self-checking bench of the sample FIFO port over APB
`timescale 1ns/1ps
`default_nettype none

module sensor_sample_fifo_port_tb;
  localparam int DEPTH = 16;
  localparam logic [5:0] UPPER = 6'h2B; // Arbitrary address bits
  localparam logic [31:0] ID_EXP = {24'h000000, 1'b0, UPPER, 1'b0};
  logic clk, rst_b, psel, penable, pwrite, fire, tick, irq;
  logic pready, pslverr, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [ssfp_pkg::SAMPLE_BYTES*8-1:0] sbytes;
  logic [ssfp_pkg::EXT_BYTES-1:0] assigned;
  logic [ssfp_pkg::EXT_BYTES*2-1:0] owner;
  int miscompares = 0;
  int n_compared = 0;

  ssfp_fifo_port #(.DEPTH(DEPTH), .BUS_ADDR_UPPER(UPPER)) dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(tick), .sample_bytes(sbytes),
    .ext_slot_assigned(assigned), .ext_slot_owner(owner), .irq(irq));

  ssfp_sensor_model u_sensor (
    .clk(clk), .rst_b(rst_b), .fire(fire), .sample_tick(tick),
    .sample_bytes(sbytes), .ext_slot_assigned(assigned),
    .ext_slot_owner(owner));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rv, exp);
  endtask

  // High byte first so the low shadow is current
  task automatic cnt(input logic [15:0] exp);
    rdchk(ssfp_pkg::ADDR_COUNT_HIGH, {24'h000000, exp[15:8]});
    rdchk(ssfp_pkg::ADDR_COUNT_LOW, {24'h000000, exp[7:0]});
  endtask

  // One tick, then wait out the 38-cycle scan
  task automatic sample();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (45) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fire = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk(ssfp_pkg::ADDR_IDENTITY, ID_EXP);
    cnt(16'h0000);
    rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h00000000);
    apb(1'b0, 12'h100, 32'h00000000);
    check({31'h0, err_seen}, 32'h00000001);
    apb(1'b1, ssfp_pkg::ADDR_DATA_PORT, 32'h0000005A);
    cnt(16'h0000);
    apb(1'b1, ssfp_pkg::ADDR_CONTROL, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ssfp_pkg::ADDR_DATA_PORT, 32'hC0 + i);
    end
    cnt(16'h0003);
    apb(1'b1, ssfp_pkg::ADDR_DATA_PORT, 32'h000000C3);
    rdchk(ssfp_pkg::ADDR_COUNT_LOW, 32'h00000003);
    for (int i = 0; i < 4; i++) begin
      rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'hC0 + i);
    end
    rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h000000C3);
    cnt(16'h0000);
    // Accelerometer only: six bytes in register order
    apb(1'b1, ssfp_pkg::ADDR_SOURCE_EN, 32'h00000008);
    sample();
    cnt(16'h0006);
    for (int i = 0; i < 6; i++) begin
      rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h40 + i);
    end
    // Fourth slave alone: its enable sits in the aux control register
    apb(1'b1, ssfp_pkg::ADDR_SOURCE_EN, 32'h00000000);
    apb(1'b1, ssfp_pkg::ADDR_AUX_CTRL, 32'h00000001);
    sample();
    cnt(16'h0006);
    for (int i = 0; i < 6; i++) begin
      rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h51 + 4 * i);
    end
    // Every source into a small buffer overflows, interrupt masked
    apb(1'b1, ssfp_pkg::ADDR_SOURCE_EN, 32'h000000FF);
    apb(1'b1, ssfp_pkg::ADDR_AUX_CTRL, 32'h00000001);
    sample();
    cnt(16'(DEPTH));
    rdchk(ssfp_pkg::ADDR_IRQ_STATUS, 32'h00000001);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b1, ssfp_pkg::ADDR_IRQ_MASK, 32'h00000001);
    check({31'h0, irq}, 32'h00000001);
    for (int i = 0; i < DEPTH; i++) begin
      rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h66 - DEPTH + i);
    end
    apb(1'b1, ssfp_pkg::ADDR_IRQ_STATUS, 32'h00000001);
    rdchk(ssfp_pkg::ADDR_IRQ_STATUS, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
    // Disabled buffer keeps its byte; reset bit empties it
    apb(1'b1, ssfp_pkg::ADDR_DATA_PORT, 32'h00000077);
    apb(1'b1, ssfp_pkg::ADDR_CONTROL, 32'h00000000);
    rdchk(ssfp_pkg::ADDR_DATA_PORT, 32'h00000065);
    cnt(16'h0001);
    apb(1'b1, ssfp_pkg::ADDR_CONTROL, 32'h00000002);
    rdchk(ssfp_pkg::ADDR_CONTROL, 32'h00000000);
    apb(1'b1, ssfp_pkg::ADDR_CONTROL, 32'h00000001);
    cnt(16'h0000);
    tally_and_finish();
  end
endmodule

`default_nettype wire
